// file: rs_pkg.sv
/*
 * Constants shared by the repeated start sequencer and its baud counter.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
package rs_pkg;
    // -------------------------------------------------------------------
    // Control and status bit positions and baud reload widths
    // -------------------------------------------------------------------
    localparam int REPEATED_START_BIT = 1;
    localparam int START_SEEN_BIT     = 3;
    localparam int CTRL_LOW_BITS      = 5;
    localparam int SHORT_RELOAD_MSB   = 5;
    localparam int RELOAD_WIDTH       = 7;

    // -------------------------------------------------------------------
    // Values after reset
    // -------------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] BUFFER_RESET  = 8'h00;

    // -------------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SCL_LOW,
        ST_SDA_HIGH,
        ST_SCL_RISE,
        ST_BOTH_HIGH,
        ST_SDA_LOW
    } rs_state_t;
endpackage

// file: baud_if.sv
/*
 * Interface between the sequencer and its baud rate counter.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface baud_if;
    logic       load;
    logic [6:0] reload;
    logic       timeout;
    logic       busy;

    modport ctrl (output load, output reload, input timeout, input busy);
    modport gen  (input load, input reload, output timeout, output busy);
endinterface

// file: baud_counter.sv
/*
 * Reloadable down counter that times one baud period.
 * Assumes load is a one-cycle pulse from the sequencer on the same clock.
 */
`timescale 1ns/1ps
module baud_counter
    import rs_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic clock_enable,
    // Sequencer side
    baud_if.gen       bif
);
    logic [6:0] count;

    // A reload of zero still lasts one cycle, so a period is reload+1 cycles.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            count       <= 7'h00;
            bif.busy    <= 1'b0;
            bif.timeout <= 1'b0;
        end
        else if (clock_enable)
        begin
            bif.timeout <= 1'b0;
            if (bif.load)
            begin
                count    <= bif.reload;
                bif.busy <= 1'b1;
            end
            else if (bif.busy)
            begin
                if (count == 7'h00)
                begin
                    bif.busy    <= 1'b0;
                    bif.timeout <= 1'b1;
                end
                else
                begin
                    count <= count - 7'h01;
                end
            end
        end
    end
endmodule // baud_counter

// file: i2c_master_repeated_start.sv
/*
 * Repeated start sequencer of an I2C master port with collision checks and
 * write blocking while the sequence runs.
 * Assumes bus line inputs are already synchronous to clock; open-drain pads
 * are built outside from the output-enable signals (enable high pulls low).
 */
// What this block does
// [RQ1] Start only on request while idle
// [RQ2] Drive SCL low once requested
// [RQ3] SCL low loads baud from reload 5:0
// [RQ4] Release SDA high one baud period
// [RQ5] Timeout and SDA high releases SCL
// [RQ6] SCL high reloads baud from 6:0
// [RQ7] Both high one period, then SDA low
// [RQ8] Clear request, no reload, keep SDA low
// [RQ9] Set start-seen flag on start detection
// [RQ10] Irq flag after final period expires
// [RQ11] Request during other event is ignored
// [RQ12] Collision: SDA low at rise, early SCL fall
// [RQ13] Software may then load address byte
// [RQ14] Software may then send further eight bits
// [RQ15] Buffer write during sequence sets collision
// [RQ16] Low control bits locked until complete
// [RQ17] Collision aborts, releases lines, goes idle
`timescale 1ns/1ps
module i2c_master_repeated_start
    import rs_pkg::*;
#(
    parameter int DATA_WIDTH = 8
)
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  clock_enable,
    // Software control
    input  wire logic                  control_write,
    input  wire logic [7:0]            control_wdata,
    input  wire logic                  buffer_write,
    input  wire logic [DATA_WIDTH-1:0] buffer_wdata,
    input  wire logic [RELOAD_WIDTH-1:0] baud_reload_value,
    input  wire logic                  irq_flag_clear,
    input  wire logic                  write_collision_flag_clear,
    input  wire logic                  collision_clear,
    input  wire logic                  other_event_busy,
    // Bus lines
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       scl_oe,
    output logic                       sda_oe,
    // Status
    output logic [7:0]                 serial_control_two,
    output logic [7:0]                 serial_port_status,
    output logic [DATA_WIDTH-1:0]      transmit_buffer,
    output logic                       serial_port_irq_flag,
    output logic                       write_collision_flag,
    output logic                       bus_collision_flag
);
    rs_state_t state;
    logic      scl_prev;
    logic      sda_prev;
    logic      seq_active;
    logic      start_edge;
    logic      collide;
    logic      finish;
    logic      period_done;

    baud_if bif ();

    baud_counter u_baud (
        .clock        (clock),
        .rst_b        (rst_b),
        .clock_enable (clock_enable),
        .bif          (bif.gen)
    );

    assign seq_active = (state != ST_IDLE);
    assign start_edge = sda_prev && !sda_in && scl_in && scl_prev;
    // A timeout left over from an aborted period can land in the cycle in which a
    // new load is issued. It is ignored there so the new period runs in full.
    assign period_done = bif.timeout && !bif.load;
    assign finish      = (state == ST_SDA_LOW) && period_done;

    // -------------------------------------------------------------------
    // Collision detection
    // -------------------------------------------------------------------
    always_comb
    begin
        collide = 1'b0;
        if (state == ST_SCL_RISE && scl_in && !scl_prev && !sda_in)
            collide = 1'b1; // RQ12
        if ((state == ST_BOTH_HIGH) && !scl_in)
            collide = 1'b1; // RQ12
    end

    // -------------------------------------------------------------------
    // Sequencer and baud loads
    // -------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state      <= ST_IDLE;
            scl_oe     <= 1'b0;
            sda_oe     <= 1'b0;
            bif.load   <= 1'b0;
            bif.reload <= 7'h00;
            scl_prev   <= 1'b1;
            sda_prev   <= 1'b1;
        end
        else if (clock_enable)
        begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
            bif.load <= 1'b0;
            if (collide)
            begin
                state  <= ST_IDLE; // RQ17
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (serial_control_two[REPEATED_START_BIT]) // RQ1
                        begin
                            scl_oe <= 1'b1; // RQ2
                            state  <= ST_SCL_LOW;
                        end
                    end
                    ST_SCL_LOW:
                    begin
                        if (!scl_in)
                        begin
                            bif.reload <= {1'b0, baud_reload_value[SHORT_RELOAD_MSB:0]}; // RQ3
                            bif.load   <= 1'b1;
                            sda_oe     <= 1'b0; // RQ4
                            state      <= ST_SDA_HIGH;
                        end
                    end
                    ST_SDA_HIGH:
                    begin
                        if (period_done && sda_in)
                        begin
                            scl_oe <= 1'b0; // RQ5
                            state  <= ST_SCL_RISE;
                        end
                    end
                    ST_SCL_RISE:
                    begin
                        if (scl_in)
                        begin
                            bif.reload <= baud_reload_value; // RQ6
                            bif.load   <= 1'b1;
                            state      <= ST_BOTH_HIGH;
                        end
                    end
                    ST_BOTH_HIGH:
                    begin
                        if (period_done && sda_in)
                        begin
                            sda_oe     <= 1'b1; // RQ7
                            bif.reload <= baud_reload_value;
                            bif.load   <= 1'b1;
                            state      <= ST_SDA_LOW;
                        end
                    end
                    ST_SDA_LOW:
                    begin
                        // SDA stays driven low and no further reload is issued.
                        if (period_done)
                            state <= ST_IDLE; // RQ8
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // Second control register
    // -------------------------------------------------------------------
    // Events cannot be queued, so the low bits freeze while a sequence runs.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            serial_control_two <= CONTROL_RESET;
        else if (clock_enable)
        begin
            if (control_write && !seq_active) // RQ1
            begin
                serial_control_two <= control_wdata; // RQ16
                if (other_event_busy)
                    serial_control_two[REPEATED_START_BIT] <= 1'b0; // RQ11
            end
            else if (control_write)
                serial_control_two[7:CTRL_LOW_BITS] <= control_wdata[7:CTRL_LOW_BITS]; // RQ16
            // The automatic clear comes last, so a same-cycle write keeps its upper bits.
            if (finish || collide)
                serial_control_two[REPEATED_START_BIT] <= 1'b0; // RQ8
        end
    end

    // -------------------------------------------------------------------
    // Status, buffer and flags
    // -------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            serial_port_status <= STATUS_RESET;
        else if (clock_enable && start_edge)
            serial_port_status[START_SEEN_BIT] <= 1'b1; // RQ9
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            serial_port_irq_flag <= 1'b0;
        else if (clock_enable)
        begin
            if (finish)
                serial_port_irq_flag <= 1'b1; // RQ10
            else if (irq_flag_clear)
                serial_port_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            transmit_buffer      <= BUFFER_RESET[DATA_WIDTH-1:0];
            write_collision_flag <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (buffer_write && seq_active)
                write_collision_flag <= 1'b1; // RQ15
            else
            begin
                if (write_collision_flag_clear)
                    write_collision_flag <= 1'b0;
                if (buffer_write)
                    transmit_buffer <= buffer_wdata; // RQ13 RQ14
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            bus_collision_flag <= 1'b0;
        else if (clock_enable)
        begin
            if (collide)
                bus_collision_flag <= 1'b1; // RQ12
            else if (collision_clear)
                bus_collision_flag <= 1'b0;
        end
    end
endmodule // i2c_master_repeated_start

// file: i2c_master_repeated_start_checker.sv
/* Port checker for the repeated start sequencer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module i2c_master_repeated_start_checker
    import rs_pkg::*;
#(
    parameter int DATA_WIDTH = 8
)
(
    // Clock and software controls
    input wire logic                  clock,
    input wire logic                  rst_b,
    input wire logic                  clock_enable,
    input wire logic                  control_write,
    input wire logic                  buffer_write,
    input wire logic                  other_event_busy,
    // Bus lines
    input wire logic                  scl_in,
    input wire logic                  sda_in,
    input wire logic                  scl_oe,
    input wire logic                  sda_oe,
    // Status
    input wire logic [7:0]            serial_control_two,
    input wire logic [7:0]            serial_port_status,
    input wire logic [DATA_WIDTH-1:0] transmit_buffer,
    input wire logic                  serial_port_irq_flag,
    input wire logic                  write_collision_flag,
    input wire logic                  bus_collision_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic rs_req = serial_control_two[REPEATED_START_BIT];

    sequence s_req_rise;
        $rose(rs_req);
    endsequence
    sequence s_seq_end;
        $fell(rs_req) && sda_oe && !scl_oe && $past(sda_oe);
    endsequence

    a_req_drives_scl: assert property (s_req_rise ##0 clock_enable |=> scl_oe)
        else $error("SCL not driven after request");
    a_busy_drops_req: assert property (
        control_write && clock_enable && other_event_busy && !rs_req |=> !rs_req)
        else $error("Request taken while busy");
    a_low_bits_locked: assert property (
        control_write && clock_enable && rs_req
        |=> $stable({serial_control_two[4:2], serial_control_two[0]}))
        else $error("Low control bits changed in sequence");
    a_write_collision_flag_on_write: assert property (
        buffer_write && clock_enable && rs_req
        |=> write_collision_flag && $stable(transmit_buffer))
        else $error("Buffer write in sequence not blocked");
    a_scl_release_sda: assert property ($fell(scl_oe) |-> $past(sda_in))
        else $error("SCL released while SDA low");
    a_sda_low_scl_high: assert property (
        $rose(sda_oe) |-> !scl_oe && $past(scl_in) && $past(sda_in))
        else $error("SDA driven without both lines high");
    a_irq_ends_seq: assert property ($rose(serial_port_irq_flag) |-> s_seq_end)
        else $error("Irq flag without sequence end");
    a_coll_releases: assert property (
        $rose(bus_collision_flag) |-> ##[0:1] !scl_oe && !sda_oe && !rs_req)
        else $error("Collision did not abort");
    a_start_seen_set: assert property (
        clock_enable && $fell(sda_in) && scl_in && $past(scl_in)
        |-> ##[0:3] serial_port_status[START_SEEN_BIT])
        else $error("Start condition not flagged");
endmodule // i2c_master_repeated_start_checker

bind i2c_master_repeated_start i2c_master_repeated_start_checker #(.DATA_WIDTH(DATA_WIDTH))
    u_checker (.clock, .rst_b, .clock_enable, .control_write, .buffer_write,
    .other_event_busy, .scl_in, .sda_in, .scl_oe, .sda_oe, .serial_control_two,
    .serial_port_status, .transmit_buffer, .serial_port_irq_flag,
    .write_collision_flag, .bus_collision_flag);

// file: i2c_bus_partner.sv
/* Other parties on the shared two-wire bus.
   Assumes open-drain lines with pull-ups; any enable pulls a line low. */
`timescale 1ns/1ps
module i2c_bus_partner
(
    // Port drivers
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Far-side behaviour
    input wire logic stretch,
    input wire logic grab_sda,
    // Wire levels
    output logic     scl_in,
    output logic     sda_in
);
    // A slow target holds SCL low; a rival master pulls SDA low.
    assign scl_in = !(scl_oe || stretch);
    assign sda_in = !(sda_oe || grab_sda);
endmodule // i2c_bus_partner

// file: i2c_master_repeated_start_tb_top.sv
/* Self-checking bench for the repeated start sequencer.
   Assumes the bus partner model and the bound port checker. */
`timescale 1ns/1ps
module i2c_master_repeated_start_tb_top
    import rs_pkg::*;
();
    logic clock, rst_b, clock_enable, control_write, buffer_write, irq_flag_clear;
    logic write_collision_flag_clear, collision_clear, other_event_busy, stretch, grab_sda;
    logic scl_in, sda_in, scl_oe, sda_oe, serial_port_irq_flag;
    logic write_collision_flag, bus_collision_flag;
    logic [7:0] control_wdata, buffer_wdata, exp_buf, serial_control_two;
    logic [7:0] serial_port_status, transmit_buffer;
    logic [6:0] baud_reload_value, r;
    int n_errors, checked, b_lo, b_hi, b_sl, lo, hi, sl;

    i2c_master_repeated_start u_i2c_master_repeated_start (.clock, .rst_b, .clock_enable,
        .control_write, .control_wdata, .buffer_write, .buffer_wdata, .baud_reload_value,
        .irq_flag_clear, .write_collision_flag_clear, .collision_clear, .other_event_busy, .scl_in,
        .sda_in, .scl_oe, .sda_oe, .serial_control_two, .serial_port_status,
        .transmit_buffer, .serial_port_irq_flag, .write_collision_flag, .bus_collision_flag);
    i2c_bus_partner u_i2c_bus_partner (.scl_oe, .sda_oe, .stretch, .grab_sda, .scl_in, .sda_in);

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task tick;
        @(posedge clock);
        #2;
    endtask
    task chk(input logic c, input string m);
        checked++;
        if (c !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task final_report;
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Phase lengths grow by one cycle per reload count and per frozen cycle.
    function automatic int exp_len(input int base, input int rl, input int fz);
        return base + rl - 5 + fz;
    endfunction
    task lim(input int k, input int m);
        chk(k < m, "wait timed out");
        if (k >= m)
            final_report;
    endtask
    task wr_ctrl(input logic [7:0] d);
        control_wdata = d;
        control_write = 1'b1;
        tick;
        control_write = 1'b0;
    endtask

    // Durations are compared against a base run, so fixed pipeline
    // offsets of the design cancel out and only baud periods remain.
    task automatic run(input logic [6:0] rl, input int fz, output int lo, output int hi,
                       output int sl);
        logic [2:0] v;
        int k;
        v = 3'($urandom);
        baud_reload_value = rl;
        wr_ctrl({3'($urandom), 5'h02});
        for (k = 0; scl_oe !== 1'b1 && k < 300; k++) tick;
        lim(k, 300);
        for (lo = 0; scl_oe === 1'b1 && lo < 300; lo++)
        begin
            clock_enable = (lo < 2 || lo >= 2 + fz);
            tick;
        end
        clock_enable = 1'b1;
        buffer_wdata = 8'($urandom);
        control_wdata = {v, 5'h1d};
        for (hi = 0; sda_oe !== 1'b1 && hi < 300; hi++)
        begin
            buffer_write = (hi == 1);
            control_write = (hi == 1);
            tick;
        end
        buffer_write = 1'b0;
        control_write = 1'b0;
        for (sl = 0; serial_port_irq_flag !== 1'b1 && sl < 300; sl++) tick;
        lim(lo, 300);
        lim(hi, 300);
        lim(sl, 300);
        chk(serial_control_two === {v, 5'h00}, "control after sequence");
        chk(sda_oe === 1'b1 && scl_oe === 1'b0, "lines at end");
        chk(serial_port_status[START_SEEN_BIT] === 1'b1, "start not seen");
        chk(write_collision_flag === 1'b1 && transmit_buffer === exp_buf, "blocked write");
        exp_buf = 8'($urandom);
        buffer_wdata = exp_buf;
        buffer_write = 1'b1;
        tick;
        chk(transmit_buffer === exp_buf, "buffer load after irq");
        exp_buf = 8'($urandom);
        buffer_wdata = exp_buf;
        tick;
        buffer_write = 1'b0;
        chk(transmit_buffer === exp_buf, "further eight bits");
        irq_flag_clear = 1'b1;
        write_collision_flag_clear = 1'b1;
        tick;
        irq_flag_clear = 1'b0;
        write_collision_flag_clear = 1'b0;
        chk(serial_port_irq_flag === 1'b0 && write_collision_flag === 1'b0, "flag clear");
    endtask

    task automatic coll(input logic both_high);
        int k;
        baud_reload_value = 7'h20;
        wr_ctrl(8'h02);
        for (k = 0; scl_oe !== 1'b1 && k < 300; k++) tick;
        lim(k, 300);
        for (k = 0; scl_oe !== 1'b0 && k < 300; k++) tick;
        lim(k, 300);
        stretch = !both_high;
        repeat (3) tick;
        grab_sda = !both_high;
        stretch = both_high;
        for (k = 0; bus_collision_flag !== 1'b1 && k < 20; k++) tick;
        lim(k, 20);
        tick;
        chk(scl_oe === 1'b0 && sda_oe === 1'b0 && serial_control_two[1] === 1'b0
            && serial_port_irq_flag === 1'b0, "collision abort");
        stretch = 1'b0;
        grab_sda = 1'b0;
        collision_clear = 1'b1;
        tick;
        collision_clear = 1'b0;
        chk(bus_collision_flag === 1'b0, "collision clear");
    endtask

    initial
    begin
        {rst_b, control_write, buffer_write, irq_flag_clear, write_collision_flag_clear} = 5'h00;
        {collision_clear, other_event_busy, stretch, grab_sda} = 4'h0;
        clock_enable = 1'b1;
        control_wdata = 8'h00;
        buffer_wdata = 8'h00;
        baud_reload_value = 7'h00;
        exp_buf = 8'h00;
        n_errors = 0;
        checked = 0;
        void'($urandom(32'hda935f55));
        repeat (8) tick;
        rst_b = 1'b1;
        tick;
        chk({serial_control_two, serial_port_status, transmit_buffer, serial_port_irq_flag,
             write_collision_flag, bus_collision_flag, scl_oe, sda_oe} === 29'h0, "reset");
        other_event_busy = 1'b1;
        wr_ctrl(8'h02);
        repeat (3) tick;
        chk(serial_control_two[1] === 1'b0 && scl_oe === 1'b0, "busy request");
        other_event_busy = 1'b0;
        run(7'h05, 0, b_lo, b_hi, b_sl);
        for (int i = 0; i < 7; i++)
        begin
            r = (i == 0) ? 7'h7f : (i == 1) ? 7'h40 : (i == 2) ? 7'h3f : 7'($urandom);
            run(r, i % 4, lo, hi, sl);
            chk(lo === exp_len(b_lo, int'(r[5:0]), i % 4), "low phase");
            chk(hi === exp_len(b_hi, int'(r), 0), "high phase");
            chk(sl === exp_len(b_sl, int'(r), 0), "sda low phase");
        end
        coll(1'b0);
        coll(1'b1);
        final_report;
    end
endmodule // i2c_master_repeated_start_tb_top
